// ---- hw/bfiu_unit.sv ----
// Decode and execute of jump, branch, call, return and flag instructions
`timescale 1ns/10ps
`include "bfiu_regs.svh"

// What this block does
// [RULE1] Jump relative always branches, 2 bytes, 3 cycles
// [RULE2] Never-taken relative: no branch, 2 bytes, 3 cycles
// [RULE3] Opcode 24 branches when carry is clear
// [RULE4] Opcode 25 branches when carry is set
// [RULE5] 27 branches on zero set, 26 on clear
// [RULE6] 2C on N xor V clear, 2D set
// [RULE7] 2E when Z or (N xor V) clear, 2F set
// [RULE8] 22 when C or Z clear, 23 set
// [RULE9] 2B on negative set, 2A on clear
// [RULE10] 28 on overflow clear, 29 on set
// [RULE11] Relative call: 2 bytes, 6 cycles, flags kept
// [RULE12] Jump: indexed 2/3, extended 3/3, flags kept
// [RULE13] Call: direct 2/5, indexed 2/6, extended 3/6
// [RULE14] Interrupt return: 10 cycles, restores all flags
// [RULE15] Subroutine return: 1 byte, 5 cycles, flags kept
// [RULE16] Software trap: 1 byte, 12 cycles, sets mask
// [RULE17] Halt: 9 cycles then wait for wake
// [RULE18] Carry clear/set ops, 1 byte, 2 cycles
// [RULE19] Mask clear/set ops, 1 byte, 2 cycles
// [RULE20] Overflow clear/set ops, others kept
// [RULE21] Accumulator bits 5..0 copied into flags
// [RULE22] Flags copied into accumulator, flags kept
// [RULE23] Branch offset signed, added to next address
module bfiu_unit #(
    parameter int ADDR_W = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Instruction issue
    input wire logic start,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand_hi,
    input wire logic [7:0] operand_lo,
    input wire logic [ADDR_W-1:0] pc_in,
    input wire logic [ADDR_W-1:0] index_in,
    input wire logic [7:0] acc_in,
    // Values supplied by the core at completion
    input wire logic [ADDR_W-1:0] stack_ret_in,
    input wire logic [7:0] stack_flags_in,
    input wire logic [ADDR_W-1:0] trap_vector_in,
    input wire logic wake_in,
    // Flag update from arithmetic
    input wire logic flag_load,
    input wire logic [5:0] flag_load_val,
    // Results
    output logic busy,
    output logic done,
    output logic illegal,
    output logic branch_taken,
    output logic [ADDR_W-1:0] next_pc,
    output logic [1:0] instr_len,
    output logic call_push,
    output logic [ADDR_W-1:0] return_addr,
    output logic [7:0] acc_out,
    output logic acc_we,
    output logic halted,
    output logic [7:0] condition_flags
);
    import bfiu_pkg::*;

    if (ADDR_W < 16) begin : g_width_check
        $error("bfiu_unit needs ADDR_W of at least 16");
    end

    // ==========================================
    // Decode table
    function automatic bfiu_decode_t decode_op(input logic [7:0] op);
        bfiu_decode_t d;
        d = '{cls_illegal, tgt_none, `BFIU_LEN_1, `BFIU_CYC_ILLEGAL};
        if (op[7:4] == `BFIU_OP_BRANCH_GRP) begin
            d = '{cls_branch, tgt_none, `BFIU_LEN_2, `BFIU_CYC_BRANCH}; // [RULE1]
        end else if (op == `BFIU_OP_CALL_REL) begin
            d = '{cls_call_rel, tgt_none, `BFIU_LEN_2, `BFIU_CYC_CALL_REL}; // [RULE11]
        end else if (op == `BFIU_OP_JUMP_IDX) begin
            d = '{cls_jump, tgt_idx, `BFIU_LEN_2, `BFIU_CYC_JUMP}; // [RULE12]
        end else if (op == `BFIU_OP_JUMP_EXT) begin
            d = '{cls_jump, tgt_ext, `BFIU_LEN_3, `BFIU_CYC_JUMP}; // [RULE12]
        end else if (op == `BFIU_OP_CALL_DIR) begin
            d = '{cls_call, tgt_dir, `BFIU_LEN_2, `BFIU_CYC_CALL_DIR}; // [RULE13]
        end else if (op == `BFIU_OP_CALL_IDX) begin
            d = '{cls_call, tgt_idx, `BFIU_LEN_2, `BFIU_CYC_CALL_IDX_EXT}; // [RULE13]
        end else if (op == `BFIU_OP_CALL_EXT) begin
            d = '{cls_call, tgt_ext, `BFIU_LEN_3, `BFIU_CYC_CALL_IDX_EXT}; // [RULE13]
        end else if (op == `BFIU_OP_INT_RETURN) begin
            d = '{cls_int_return, tgt_none, `BFIU_LEN_1, `BFIU_CYC_INT_RETURN}; // [RULE14]
        end else if (op == `BFIU_OP_SUB_RETURN) begin
            d = '{cls_sub_return, tgt_none, `BFIU_LEN_1, `BFIU_CYC_SUB_RETURN}; // [RULE15]
        end else if (op == `BFIU_OP_SW_TRAP) begin
            d = '{cls_sw_trap, tgt_none, `BFIU_LEN_1, `BFIU_CYC_SW_TRAP}; // [RULE16]
        end else if (op == `BFIU_OP_HALT) begin
            d = '{cls_halt, tgt_none, `BFIU_LEN_1, `BFIU_CYC_HALT}; // [RULE17]
        end else if (op >= `BFIU_OP_OVERFLOW_CLEAR && op <= `BFIU_OP_MASK_SET) begin
            d = '{cls_flag_op, tgt_none, `BFIU_LEN_1, `BFIU_CYC_FLAG_OP}; // [RULE18]
        end else if (op == `BFIU_OP_ACC_TO_FLAGS) begin
            d = '{cls_acc_to_flags, tgt_none, `BFIU_LEN_1, `BFIU_CYC_FLAG_OP}; // [RULE21]
        end else if (op == `BFIU_OP_FLAGS_TO_ACC) begin
            d = '{cls_flags_to_acc, tgt_none, `BFIU_LEN_1, `BFIU_CYC_FLAG_OP}; // [RULE22]
        end
        return d;
    endfunction

    // ==========================================
    // Reset release
    logic [1:0] rst_sync_reg;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    wire logic rst_core_n = rst_sync_reg[1];

    // ==========================================
    // State and latched instruction
    bfiu_state_t state_reg;
    bfiu_state_t state_next;
    bfiu_decode_t dec_reg;
    logic [7:0] op_reg;
    logic [7:0] hi_reg;
    logic [7:0] lo_reg;
    logic [ADDR_W-1:0] pc_reg;
    logic [ADDR_W-1:0] index_reg;
    logic [7:0] acc_reg;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [5:0] flags_reg;
    logic [5:0] flags_next;
    logic cond_take;

    wire logic take_w = start && (state_reg == st_idle);
    wire logic finish_w = (state_reg == st_exec) && (cnt_reg == 4'h1);
    wire bfiu_decode_t dec_w = decode_op(opcode);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            st_idle: begin
                if (start) begin
                    state_next = st_exec;
                    cnt_next = dec_w.cyc - 4'h1;
                end
            end
            st_exec: begin
                if (finish_w) begin
                    state_next = (dec_reg.cls == cls_halt) ? st_halt : st_idle; // [RULE17]
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            st_halt: begin
                if (wake_in) begin
                    state_next = st_idle;
                end
            end
            default: state_next = st_idle;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            state_reg <= st_idle;
            cnt_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            dec_reg <= '{cls_illegal, tgt_none, `BFIU_LEN_1, `BFIU_CYC_ILLEGAL};
            op_reg <= 8'h00;
            hi_reg <= 8'h00;
            lo_reg <= 8'h00;
            pc_reg <= '0;
            index_reg <= '0;
            acc_reg <= 8'h00;
        end else if (take_w) begin
            dec_reg <= dec_w;
            op_reg <= opcode;
            hi_reg <= operand_hi;
            lo_reg <= operand_lo;
            pc_reg <= pc_in;
            index_reg <= index_in;
            acc_reg <= acc_in;
        end
    end

    // ==========================================
    // Targets
    bfiu_branch_cond u_cond (
        .cond_sel(op_reg[3:0]),
        .flags(flags_reg),
        .take(cond_take)
    );

    wire logic [ADDR_W-1:0] seq_pc_w = pc_reg + ADDR_W'(dec_reg.len);
    wire logic [ADDR_W-1:0] rel_pc_w = seq_pc_w + ADDR_W'($signed(hi_reg)); // [RULE23]
    wire logic [ADDR_W-1:0] idx_pc_w = index_reg + ADDR_W'(hi_reg);
    wire logic [ADDR_W-1:0] ext_pc_w = ADDR_W'({hi_reg, lo_reg});
    wire logic [ADDR_W-1:0] dir_pc_w = ADDR_W'(hi_reg);
    wire logic [ADDR_W-1:0] abs_pc_w = (dec_reg.mode == tgt_idx) ? idx_pc_w :
                                       (dec_reg.mode == tgt_ext) ? ext_pc_w : dir_pc_w;
    wire logic is_branch_w = dec_reg.cls == cls_branch;
    wire logic taken_w = (is_branch_w && cond_take) || (dec_reg.cls == cls_call_rel) ||
                         (dec_reg.cls == cls_jump) || (dec_reg.cls == cls_call);
    wire logic is_call_w = (dec_reg.cls == cls_call_rel) || (dec_reg.cls == cls_call);
    // Stack words and vector are sampled on the completing edge only
    wire logic [ADDR_W-1:0] next_pc_w =
        (is_branch_w && cond_take) ? rel_pc_w : // [RULE1]
        (dec_reg.cls == cls_call_rel) ? rel_pc_w : // [RULE11]
        (dec_reg.cls == cls_jump || dec_reg.cls == cls_call) ? abs_pc_w : // [RULE12]
        (dec_reg.cls == cls_int_return) ? stack_ret_in :
        (dec_reg.cls == cls_sub_return) ? stack_ret_in : // [RULE15]
        (dec_reg.cls == cls_sw_trap) ? trap_vector_in : seq_pc_w;

    // ==========================================
    // Flags
    wire logic set_val_w = op_reg[0];
    always_comb begin
        flags_next = flags_reg;
        if (finish_w) begin
            case (dec_reg.cls)
                cls_int_return: flags_next = stack_flags_in[5:0]; // [RULE14]
                cls_sw_trap: flags_next[`BFIU_FLAG_I] = 1'b1; // [RULE16]
                cls_acc_to_flags: flags_next = acc_reg[5:0]; // [RULE21]
                cls_flag_op: begin
                    if (op_reg[3:1] == 3'(`BFIU_OP_CARRY_CLEAR >> 1)) begin
                        flags_next[`BFIU_FLAG_C] = set_val_w; // [RULE18]
                    end else if (op_reg[3:1] == 3'(`BFIU_OP_MASK_CLEAR >> 1)) begin
                        flags_next[`BFIU_FLAG_I] = set_val_w; // [RULE19]
                    end else begin
                        flags_next[`BFIU_FLAG_V] = set_val_w; // [RULE20]
                    end
                end
                default: flags_next = flags_reg;
            endcase
        end else if (flag_load && state_reg != st_exec) begin
            flags_next = flag_load_val;
        end
    end

    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            flags_reg <= `BFIU_FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ==========================================
    // Registered results
    logic halted_reg;
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            done <= 1'b0;
            illegal <= 1'b0;
            branch_taken <= 1'b0;
            call_push <= 1'b0;
            acc_we <= 1'b0;
        end else begin
            done <= finish_w;
            illegal <= finish_w && (dec_reg.cls == cls_illegal);
            branch_taken <= finish_w && taken_w;
            call_push <= finish_w && is_call_w; // [RULE13]
            acc_we <= finish_w && (dec_reg.cls == cls_flags_to_acc);
        end
    end

    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            next_pc <= '0;
            instr_len <= 2'h0;
            return_addr <= '0;
            acc_out <= 8'h00;
        end else if (finish_w) begin
            next_pc <= next_pc_w;
            instr_len <= dec_reg.len;
            return_addr <= seq_pc_w;
            acc_out <= {`BFIU_FLAGS_UPPER, flags_reg}; // [RULE22]
        end
    end

    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            busy <= 1'b0;
            halted_reg <= 1'b0;
        end else begin
            busy <= state_next == st_exec;
            halted_reg <= state_next == st_halt; // [RULE17]
        end
    end
    assign halted = halted_reg;
    assign condition_flags = {`BFIU_FLAGS_UPPER, flags_reg};

    // ==========================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_core_n);
    wire logic [7:0] br_always_w = {`BFIU_OP_BRANCH_GRP, `BFIU_BR_ALWAYS};

    AST_ALWAYS_TAKES: assert property ( // [RULE1]
        take_w && opcode == br_always_w |-> ##3 done && branch_taken)
        else $error("jump relative not taken in 3 cycles");
    AST_NEVER_TAKES: assert property ( // [RULE2]
        take_w && opcode == {`BFIU_OP_BRANCH_GRP, `BFIU_BR_NEVER}
        |-> ##3 done && !branch_taken && next_pc == $past(pc_in, 3) + ADDR_W'(2))
        else $error("never-taken branch misbehaved");
    AST_NO_CARRY_TEST: assert property ( // [RULE3]
        take_w && opcode == {`BFIU_OP_BRANCH_GRP, `BFIU_BR_NO_CARRY}
        |-> ##3 done && (branch_taken == !$past(flags_reg[`BFIU_FLAG_C])))
        else $error("no-carry branch test wrong");
    AST_EQUAL_TEST: assert property ( // [RULE5]
        take_w && opcode == {`BFIU_OP_BRANCH_GRP, `BFIU_BR_EQUAL}
        |-> ##3 branch_taken == $past(flags_reg[`BFIU_FLAG_Z]))
        else $error("equal branch test wrong");
    AST_SIGNED_GE_TEST: assert property ( // [RULE6]
        take_w && opcode == {`BFIU_OP_BRANCH_GRP, `BFIU_BR_SIGNED_GE}
        |-> ##3 branch_taken == !($past(flags_reg[`BFIU_FLAG_N]) ^ $past(flags_reg[`BFIU_FLAG_V])))
        else $error("signed ge branch test wrong");
    AST_REL_CALL_TIME: assert property ( // [RULE11]
        take_w && opcode == `BFIU_OP_CALL_REL |=> !done [*5] ##1 (done && call_push))
        else $error("relative call not done in 6 cycles");
    AST_DIRECT_CALL: assert property ( // [RULE13]
        take_w && opcode == `BFIU_OP_CALL_DIR
        |-> ##5 done && next_pc == ADDR_W'($past(operand_hi, 5)))
        else $error("direct call target or timing wrong");
    AST_INT_RETURN_FLAGS: assert property ( // [RULE14]
        take_w && opcode == `BFIU_OP_INT_RETURN
        |-> ##10 done && flags_reg == $past(stack_flags_in[5:0]))
        else $error("interrupt return flags wrong");
    AST_TRAP_MASK: assert property ( // [RULE16]
        take_w && opcode == `BFIU_OP_SW_TRAP |-> ##12 done && flags_reg[`BFIU_FLAG_I])
        else $error("software trap did not set mask in 12 cycles");
    AST_HALT_AFTER_NINE: assert property ( // [RULE17]
        take_w && opcode == `BFIU_OP_HALT |=> !halted [*8] ##1 halted)
        else $error("halt not entered after 9 cycles");
    AST_CARRY_SET: assert property ( // [RULE18]
        take_w && opcode == `BFIU_OP_CARRY_SET |-> ##2 done && flags_reg[`BFIU_FLAG_C])
        else $error("carry set op failed");
    AST_FLAGS_TO_ACC: assert property ( // [RULE22]
        take_w && opcode == `BFIU_OP_FLAGS_TO_ACC
        |-> ##2 acc_we && acc_out[5:0] == $past(flags_reg) && flags_reg == $past(flags_reg))
        else $error("flags to accumulator copy wrong");
    AST_REL_OFFSET: assert property ( // [RULE23]
        take_w && opcode == br_always_w |-> ##3 next_pc ==
        $past(pc_in, 3) + ADDR_W'(2) + ADDR_W'($signed($past(operand_hi, 3))))
        else $error("relative target wrong");
endmodule

// ---- hw/bfiu_regs.svh ----
// Opcodes, cycle counts, byte lengths and flag layout of the branch and flag unit
`ifndef BFIU_REGS_SVH
`define BFIU_REGS_SVH

// ==========================================
// Relative branch group, low nibble selects the test
`define BFIU_OP_BRANCH_GRP 4'h2
`define BFIU_BR_ALWAYS 4'h0
`define BFIU_BR_NEVER 4'h1
`define BFIU_BR_ABOVE 4'h2
`define BFIU_BR_AT_MOST 4'h3
`define BFIU_BR_NO_CARRY 4'h4
`define BFIU_BR_CARRY 4'h5
`define BFIU_BR_UNEQUAL 4'h6
`define BFIU_BR_EQUAL 4'h7
`define BFIU_BR_NO_OVERFLOW 4'h8
`define BFIU_BR_OVERFLOW 4'h9
`define BFIU_BR_POSITIVE 4'ha
`define BFIU_BR_NEGATIVE 4'hb
`define BFIU_BR_SIGNED_GE 4'hc
`define BFIU_BR_SIGNED_LT 4'hd
`define BFIU_BR_SIGNED_GT 4'he
`define BFIU_BR_SIGNED_LE 4'hf

// ==========================================
// Other opcodes
`define BFIU_OP_CALL_REL 8'h8d
`define BFIU_OP_JUMP_IDX 8'h6e
`define BFIU_OP_JUMP_EXT 8'h7e
`define BFIU_OP_CALL_DIR 8'h9d
`define BFIU_OP_CALL_IDX 8'had
`define BFIU_OP_CALL_EXT 8'hbd
`define BFIU_OP_INT_RETURN 8'h3b
`define BFIU_OP_SUB_RETURN 8'h39
`define BFIU_OP_SW_TRAP 8'h3f
`define BFIU_OP_HALT 8'h3e
`define BFIU_OP_OVERFLOW_CLEAR 8'h0a
`define BFIU_OP_OVERFLOW_SET 8'h0b
`define BFIU_OP_CARRY_CLEAR 8'h0c
`define BFIU_OP_CARRY_SET 8'h0d
`define BFIU_OP_MASK_CLEAR 8'h0e
`define BFIU_OP_MASK_SET 8'h0f
`define BFIU_OP_ACC_TO_FLAGS 8'h06
`define BFIU_OP_FLAGS_TO_ACC 8'h07

// ==========================================
// Cycle counts and byte lengths
`define BFIU_CYC_BRANCH 4'h3
`define BFIU_CYC_CALL_REL 4'h6
`define BFIU_CYC_JUMP 4'h3
`define BFIU_CYC_CALL_DIR 4'h5
`define BFIU_CYC_CALL_IDX_EXT 4'h6
`define BFIU_CYC_INT_RETURN 4'ha
`define BFIU_CYC_SUB_RETURN 4'h5
`define BFIU_CYC_SW_TRAP 4'hc
`define BFIU_CYC_HALT 4'h9
`define BFIU_CYC_FLAG_OP 4'h2
`define BFIU_CYC_ILLEGAL 4'h2
`define BFIU_LEN_1 2'h1
`define BFIU_LEN_2 2'h2
`define BFIU_LEN_3 2'h3

// ==========================================
// Flag register layout
`define BFIU_FLAG_H 5
`define BFIU_FLAG_I 4
`define BFIU_FLAG_N 3
`define BFIU_FLAG_Z 2
`define BFIU_FLAG_V 1
`define BFIU_FLAG_C 0
`define BFIU_FLAGS_RESET 6'h10
`define BFIU_FLAGS_UPPER 2'h3

`endif

// ---- hw/bfiu_pkg.sv ----
// Types shared by the branch and flag unit
package bfiu_pkg;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_exec = 2'b01,
        st_halt = 2'b10
    } bfiu_state_t;

    typedef enum logic [3:0] {
        cls_branch = 4'b0000,
        cls_call_rel = 4'b0001,
        cls_jump = 4'b0010,
        cls_call = 4'b0011,
        cls_int_return = 4'b0100,
        cls_sub_return = 4'b0101,
        cls_sw_trap = 4'b0110,
        cls_halt = 4'b0111,
        cls_flag_op = 4'b1000,
        cls_acc_to_flags = 4'b1001,
        cls_flags_to_acc = 4'b1010,
        cls_illegal = 4'b1011
    } bfiu_class_t;

    typedef enum logic [1:0] {
        tgt_dir = 2'b00,
        tgt_idx = 2'b01,
        tgt_ext = 2'b10,
        tgt_none = 2'b11
    } bfiu_mode_t;

    typedef struct packed {
        bfiu_class_t cls;
        bfiu_mode_t mode;
        logic [1:0] len;
        logic [3:0] cyc;
    } bfiu_decode_t;

endpackage

// ---- hw/bfiu_branch_cond.sv ----
// Branch test on the condition flags
`timescale 1ns/10ps
`include "bfiu_regs.svh"

module bfiu_branch_cond (
    // Test select and flags
    input wire logic [3:0] cond_sel,
    input wire logic [5:0] flags,
    // Result
    output logic take
);
    wire logic n_w = flags[`BFIU_FLAG_N];
    wire logic z_w = flags[`BFIU_FLAG_Z];
    wire logic v_w = flags[`BFIU_FLAG_V];
    wire logic c_w = flags[`BFIU_FLAG_C];
    wire logic sgn_lt_w = n_w ^ v_w;

    always_comb begin
        take = 1'b0;
        case (cond_sel)
            `BFIU_BR_ALWAYS: take = 1'b1; // [RULE1]
            `BFIU_BR_NEVER: take = 1'b0; // [RULE2]
            `BFIU_BR_NO_CARRY: take = ~c_w; // [RULE3]
            `BFIU_BR_CARRY: take = c_w; // [RULE4]
            `BFIU_BR_EQUAL: take = z_w; // [RULE5]
            `BFIU_BR_UNEQUAL: take = ~z_w; // [RULE5]
            // Printed as an OR, taken as the complement of the lt test
            `BFIU_BR_SIGNED_GE: take = ~sgn_lt_w; // [RULE6]
            `BFIU_BR_SIGNED_LT: take = sgn_lt_w; // [RULE6]
            `BFIU_BR_SIGNED_GT: take = ~(z_w | sgn_lt_w); // [RULE7]
            `BFIU_BR_SIGNED_LE: take = z_w | sgn_lt_w; // [RULE7]
            `BFIU_BR_ABOVE: take = ~(c_w | z_w); // [RULE8]
            `BFIU_BR_AT_MOST: take = c_w | z_w; // [RULE8]
            `BFIU_BR_NEGATIVE: take = n_w; // [RULE9]
            `BFIU_BR_POSITIVE: take = ~n_w; // [RULE9]
            `BFIU_BR_NO_OVERFLOW: take = ~v_w; // [RULE10]
            `BFIU_BR_OVERFLOW: take = v_w; // [RULE10]
            default: take = 1'b0;
        endcase
    end
endmodule

// ---- sim/tb_branch_and_flag_instruction_unit.sv ----
// Self-checking random bench for the branch and flag unit
`timescale 1ns/10ps

module tb_branch_and_flag_instruction_unit;
    import bfiu_pkg::*;

    // ==========================================
    // Stimulus and observed signals
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic wake_in = 1'b0;
    logic flag_load = 1'b0;
    logic [5:0] flag_load_val = 6'h00;
    logic [7:0] opcode = 8'h00, operand_hi = 8'h00, operand_lo = 8'h00;
    logic [7:0] acc_in = 8'h00, stack_flags_in = 8'h00;
    logic [15:0] pc_in = 16'h0000, index_in = 16'h0000;
    logic [15:0] stack_ret_in = 16'h0000, trap_vector_in = 16'h0000;
    logic busy, done, illegal, branch_taken, call_push, acc_we, halted;
    logic [15:0] next_pc, return_addr;
    logic [1:0] instr_len;
    logic [7:0] acc_out, condition_flags;
    int mismatches = 0;
    int n_tests = 0;
    logic [7:0] ops [20] = '{8'h8d, 8'h6e, 8'h7e, 8'h9d, 8'had, 8'hbd, 8'h3b, 8'h39, 8'h3f,
        8'h3e, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h06, 8'h07, 8'h01, 8'h00};

    bfiu_unit #(.ADDR_W(16)) i_bfiu_unit (
        .core_clk(core_clk), .rst_n(rst_n), .start(start), .opcode(opcode),
        .operand_hi(operand_hi), .operand_lo(operand_lo), .pc_in(pc_in),
        .index_in(index_in), .acc_in(acc_in), .stack_ret_in(stack_ret_in),
        .stack_flags_in(stack_flags_in), .trap_vector_in(trap_vector_in),
        .wake_in(wake_in), .flag_load(flag_load), .flag_load_val(flag_load_val),
        .busy(busy), .done(done), .illegal(illegal), .branch_taken(branch_taken),
        .next_pc(next_pc), .instr_len(instr_len), .call_push(call_push),
        .return_addr(return_addr), .acc_out(acc_out), .acc_we(acc_we),
        .halted(halted), .condition_flags(condition_flags)
    );

    always #4 core_clk = ~core_clk;

    // ==========================================
    // Expectations
    function automatic logic [3:0] exp_cyc(input logic [7:0] op);
        case (op) inside
            [8'h20:8'h2f], 8'h6e, 8'h7e: return 4'h3;
            8'h8d, 8'had, 8'hbd: return 4'h6;
            8'h9d, 8'h39: return 4'h5;
            8'h3b: return 4'ha;
            8'h3f: return 4'hc;
            8'h3e: return 4'h9;
            default: return 4'h2;
        endcase
    endfunction

    function automatic logic [1:0] exp_len(input logic [7:0] op);
        if (op == 8'h7e || op == 8'hbd) return 2'h3;
        if (op[7:4] == 4'h2 || op inside {8'h8d, 8'h6e, 8'h9d, 8'had}) return 2'h2;
        return 2'h1;
    endfunction

    // Pairs share a test; even codes branch when the test is false
    function automatic logic exp_take(input logic [3:0] sel, input logic [5:0] f);
        logic t;
        case (sel[3:1])
            3'h0: t = 1'b0;
            3'h1: t = f[0] | f[2];
            3'h2: t = f[0];
            3'h3: t = f[2];
            3'h4: t = f[1];
            3'h5: t = f[3];
            3'h6: t = f[3] ^ f[1];
            default: t = f[2] | (f[3] ^ f[1]);
        endcase
        return t ~^ sel[0];
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // One instruction; entered and left just after a rising edge
    task automatic run(input logic [7:0] op, input logic [7:0] hi);
        logic [5:0] f, ef;
        logic [15:0] epc, pc;
        logic tk, isb, iscall;
        int n;
        f = 6'($urandom);
        flag_load = 1'b1;
        flag_load_val = f;
        @(posedge core_clk);
        #1;
        flag_load = 1'b0;
        chk(condition_flags, {8'h00, 2'b11, f});
        pc = 16'($urandom);
        {opcode, operand_hi, operand_lo, pc_in, index_in} = {op, hi, 8'($urandom), pc, 16'($urandom)};
        {acc_in, stack_flags_in, stack_ret_in, trap_vector_in} = 48'({$urandom, $urandom});
        start = 1'b1;
        @(posedge core_clk);
        #1;
        start = 1'b0;
        // Loads offered while executing must be refused
        flag_load = 1'b1;
        flag_load_val = ~f;
        chk(busy, 16'h1);
        n = 0;
        while (done !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        flag_load = 1'b0;
        isb = op[7:4] == 4'h2;
        iscall = op inside {8'h8d, 8'h9d, 8'had, 8'hbd};
        tk = isb ? exp_take(op[3:0], f) : (iscall || op inside {8'h6e, 8'h7e});
        case (op) inside
            [8'h20:8'h2f], 8'h8d: epc = tk ? pc + 16'h2 + {{8{hi[7]}}, hi} : pc + 16'h2;
            8'h6e, 8'had: epc = index_in + {8'h00, hi};
            8'h7e, 8'hbd: epc = {hi, operand_lo};
            8'h9d: epc = {8'h00, hi};
            8'h3b, 8'h39: epc = stack_ret_in;
            8'h3f: epc = trap_vector_in;
            default: epc = pc + 16'h1;
        endcase
        ef = f;
        case (op)
            8'h3b: ef = stack_flags_in[5:0];
            8'h3f: ef[4] = 1'b1;
            8'h0a, 8'h0b: ef[1] = op[0];
            8'h0c, 8'h0d: ef[0] = op[0];
            8'h0e, 8'h0f: ef[4] = op[0];
            8'h06: ef = acc_in[5:0];
            default: ef = f;
        endcase
        chk(16'(n + 1), {12'h000, exp_cyc(op)});
        chk(instr_len, exp_len(op));
        chk(condition_flags, {8'h00, 2'b11, ef});
        chk(illegal, op == 8'h01 || op == 8'h00);
        chk(acc_we, op == 8'h07);
        if (op == 8'h07) chk(acc_out, {8'h00, 2'b11, f});
        if (op != 8'h3e) chk(next_pc, epc);
        chk(branch_taken, tk);
        if (iscall) chk(return_addr, pc + 16'(exp_len(op)));
        chk(call_push, iscall);
        if (op == 8'h3e) begin
            chk(halted, 16'h1);
            opcode = 8'h0d;
            start = 1'b1;
            wake_in = 1'b1;
            @(posedge core_clk);
            #1;
            start = 1'b0;
            wake_in = 1'b0;
            chk(halted, 16'h0);
            chk(busy, 16'h0);
        end
        @(posedge core_clk);
        #1;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(5571));
        repeat (16) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk(condition_flags, 16'h00d0);
        chk(busy, 16'h0);
        for (int r = 0; r < 6; r++) begin
            // Offset extremes first, random after
            for (int i = 0; i < 16; i++) begin
                run({4'h2, 4'(i)}, r == 0 ? 8'h80 : r == 1 ? 8'h7f : 8'($urandom));
            end
            foreach (ops[k]) begin
                run(ops[k], r == 0 ? 8'hff : 8'($urandom));
            end
        end
        end_sim();
    end

    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
endmodule
